// file: hw/reset_power_ctrl.v
// Reset handling, stubbed power control and port ownership, with an AXI4-Lite slave
`include "rst_pwr_regs.vh"
module reset_power_ctrl (
  input wire clk_sys,
  input wire rst,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port1In,
  input wire [7:0] port3In,
  output reg [7:0] port1Out,
  output reg [7:0] port3Out,
  output wire [7:0] port1Oe,
  output wire [7:0] port3Oe,
  output wire port0Gpio,
  output wire port2Gpio,
  output wire emulationActive,
  output wire coreRunning,
  output reg internalResetDone
);
  reg [7:0] powerCtl_reg;
  reg [3:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;
  reg [7:0] port1Latch_reg;
  reg [7:0] port3Latch_reg;
  wire resetDoneRaw;
  wire awFire;
  wire wFire;
  wire writeCommit;
  wire readFire;
  reg [7:0] powerCtl_next;
  reg [7:0] port1Latch_next;
  reg [7:0] port3Latch_next;
  reg [31:0] readData_next;

  // True when an address hits a mapped register
  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `PWRCTL_OFFSET) || (addr == `PORTCTL_OFFSET) ||
               (addr == `PORTSTAT_OFFSET) || (addr == `RSTSTAT_OFFSET);
    end
  endfunction

  // Response code for an access; unmapped offsets answer with an error
  function [1:0] respFor;
    input [3:0] addr;
    begin
      if (mapped(addr))
        respFor = `AXI_RESP_OKAY;
      else
        respFor = `AXI_RESP_SLVERR;
    end
  endfunction

  // Reset length monitor on the system clock
  reset_stretch #(
    .MIN_CYCLES(`RST_MIN_OSC_PERIODS)
  ) uStretch (
    .clk_sys(clk_sys),
    .rst(rst),
    .resetDone(resetDoneRaw)
  );

  // Ports 0/2 never offered as GPIO; no emulation; power bits never stop the core
  assign port0Gpio = 1'b0;
  assign port2Gpio = 1'b0;
  assign emulationActive = 1'b0;
  assign coreRunning = ~rst;
  // Quasi-bidirectional ports: output enable follows the output, set only where a one is output
  assign port1Oe = port1Out;
  assign port3Oe = port3Out;

  // Channel readiness: accept each write half once, read when no answer pending
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Channel handshakes taken at this edge
  assign awFire = s_axi_awvalid & s_axi_awready;
  assign wFire = s_axi_wvalid & s_axi_wready;
  assign readFire = s_axi_arvalid & s_axi_arready;
  // Write commits once both halves are held and no answer is pending
  assign writeCommit = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  // Next register contents for a committing write, byte lanes honoured
  always @*
  begin
    powerCtl_next = powerCtl_reg;
    port1Latch_next = port1Latch_reg;
    port3Latch_next = port3Latch_reg;
    if (writeCommit)
    begin
      if (awAddr_reg == `PWRCTL_OFFSET && wStrb_reg[0])
      begin
        // Idle and power-down bits only stored; no flag bit exists
        powerCtl_next = wData_reg[7:0] & `PWRCTL_MASK;
      end
      if (awAddr_reg == `PORTCTL_OFFSET)
      begin
        if (wStrb_reg[0])
          port1Latch_next = wData_reg[7:0];
        if (wStrb_reg[1])
          port3Latch_next = wData_reg[15:8];
      end
    end
  end

  // Read data for the offset on the read address channel
  always @*
  begin
    case (s_axi_araddr)
      `PWRCTL_OFFSET: readData_next = {24'h000000, powerCtl_reg};
      `PORTCTL_OFFSET: readData_next = {16'h0000, port3Latch_reg, port1Latch_reg};
      `PORTSTAT_OFFSET: readData_next = {16'h0000, port3In, port1In};
      `RSTSTAT_OFFSET: readData_next = {31'h00000000, internalResetDone};
      default: readData_next = 32'h00000000;
    endcase
  end

  // Port pin outputs go to all ones asynchronously on reset
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      port1Out <= `PORT_RESET_VALUE;
      port3Out <= `PORT_RESET_VALUE;
    end
    else
    begin
      port1Out <= port1Latch_reg;
      port3Out <= port3Latch_reg;
    end
  end

  // Internal state resets synchronously
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      powerCtl_reg <= 8'h00;
      port1Latch_reg <= `PORT_RESET_VALUE;
      port3Latch_reg <= `PORT_RESET_VALUE;
      awAddr_reg <= 4'h0;
      awHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      wHeld_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `AXI_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      internalResetDone <= 1'b0;
    end
    else
    begin
      internalResetDone <= resetDoneRaw | internalResetDone;
      if (awFire)
      begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
      end
      if (wFire)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
      end
      // Commit write once both halves are held
      powerCtl_reg <= powerCtl_next;
      port1Latch_reg <= port1Latch_next;
      port3Latch_reg <= port3Latch_next;
      if (writeCommit)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= respFor(awAddr_reg);
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Read answer one cycle after the address is taken
      if (readFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= respFor(s_axi_araddr);
        s_axi_rdata <= readData_next;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: hw/rst_pwr_regs.vh
// Register offsets, field positions and timing counts for reset and power control
`ifndef RST_PWR_REGS_VH
`define RST_PWR_REGS_VH
`define PWRCTL_OFFSET 4'h0
`define PORTCTL_OFFSET 4'h4
`define PORTSTAT_OFFSET 4'h8
`define RSTSTAT_OFFSET 4'hc
`define PWRCTL_IDLE_BIT 0
`define PWRCTL_PDOWN_BIT 1
`define PWRCTL_MASK 8'h03
`define PORT_RESET_VALUE 8'hff
`define RST_MIN_OSC_PERIODS 24
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10
`endif

// file: hw/reset_stretch.v
// Counts clock edges with reset high and flags a completed internal reset
module reset_stretch #(
  parameter MIN_CYCLES = 24
) (
  input wire clk_sys,
  input wire rst,
  output reg resetDone = 1'b0
);
  // Known start so a short first reset still reports not done
  reg [5:0] holdCount_reg = 6'h00;

  // Synchronous count of reset-high edges; done once minimum seen
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      if (holdCount_reg < MIN_CYCLES[5:0])
        holdCount_reg <= holdCount_reg + 6'h01;
      resetDone <= (holdCount_reg >= MIN_CYCLES[5:0] - 6'h01);
    end
    else
    begin
      holdCount_reg <= 6'h00;
    end
  end
endmodule

// file: verification/reset_source.sv
// Reset source model
module reset_source #(parameter HOLD = 24) (
  input wire clk_sys,
  input wire go,
  output logic rst
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 4;
  // Rising edge after time zero so the async pin reset sees it
  initial
  begin
    rst = 1'b0;
    #1 rst = 1'b1;
  end
  // Raise at once, release after HOLD edges
  always @(posedge clk_sys or posedge go)
    if (go)
    begin
      rst <= 1'b1;
      cnt <= HOLD;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
    else
      rst <= 1'b0;
endmodule

// file: verification/reset_power_ctrl_assertions.sv
// Port checker
module reset_power_ctrl_assertions (
  input wire clk_sys,
  input wire rst,
  input wire s_axi_bvalid,
  input wire s_axi_rvalid,
  input wire [7:0] port1Out,
  input wire [7:0] port3Out,
  input wire port0Gpio,
  input wire port2Gpio,
  input wire emulationActive,
  input wire coreRunning,
  input wire internalResetDone
);
  default clocking @(posedge clk_sys); endclocking
  a_pins_reset: assert property (rst |-> (port1Out & port3Out) == 8'hff)
    else $error("pins");
  a_bus_reset: assert property (rst |=> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus");
  a_done_reset: assert property (rst |=> !internalResetDone)
    else $error("done");
  a_core_runs: assert property (coreRunning == !rst)
    else $error("core");
  a_no_emulation: assert property (!emulationActive)
    else $error("emul");
  a_no_gpio: assert property (!port0Gpio && !port2Gpio)
    else $error("gpio");
endmodule
bind reset_power_ctrl reset_power_ctrl_assertions u_chk (.*);

// file: verification/reset_power_ctrl_test.sv
// Bench for reset and power control
module reset_power_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, go = 0, rst, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, port0Gpio, port2Gpio, emulationActive, coreRunning;
  logic internalResetDone;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdVal;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] port1In = 8'h3c, port3In = 8'hc3, port1Out, port3Out, port1Oe, port3Oe;
  int badCount = 0, nTests = 0;
  always #10 clk_sys = ~clk_sys;
  reset_source u_src (.clk_sys(clk_sys), .go(go), .rst(rst));
  reset_power_ctrl u_dut (.*);
  task chk(input string n, input logic [31:0] got, exp);
    nTests++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  // Write with both halves offered together
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    while (!s_axi_rvalid);
    {rdVal, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask
  task testDone;
    $display("checks %0d bad %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #40000;
    badCount++;
    testDone;
  end
  initial
  begin
    @(negedge rst);
    rd(4'hc);
    chk("short", rdVal, 0);
    wr(4'h4, 32'ha55a);
    chk("bresp", resp, 0);
    repeat (2) @(negedge clk_sys);
    chk("p3", {port3Out, port1Out}, 16'ha55a);
    chk("oe", {port3Oe, port1Oe}, 16'ha55a);
    #5 go = 1;
    #1 chk("async", {port3Out, port1Out}, 16'hffff);
    @(posedge clk_sys) go <= 0;
    @(negedge rst);
    rd(4'hc);
    chk("long", rdVal, 1);
    rd(4'h4);
    chk("latch", rdVal, 32'hffff);
    $display("reset test done");
    wr(4'h0, 32'hff);
    rd(4'h0);
    chk("pwr", rdVal, 32'h3);
    rd(4'h8);
    chk("pins", rdVal, 32'hc33c);
    chk("run", coreRunning, 1);
    chk("own", {port0Gpio, port2Gpio, emulationActive}, 0);
    $display("power test done");
    testDone;
  end
endmodule
